/* File: src/eei_slave.sv */
/*
 * Two-wire slave front end: start/stop detection, slave address
 * match, acknowledge drive, array address capture and write guard.
 * Assumes: the bus master owns SCL; the boundary latch input is a
 * constant fixed at build time; write sequencing and read data
 * transmission sit in downstream logic fed by the outputs here.
 */
`timescale 1ns/1ps

//
// Contract
// - address byte is type, select, direction
// - match device type 1010 only
// - absent select bit must be zero
// - select bit must equal strap input
// - select and msb pick 64K block
// - direction bit one reads, zero writes
// - receiver acks low on ninth clock
// - transmitter releases SDA for ack
// - first address byte gives bits 15-8
// - second address byte gives bits 7-0
// - SDA only pulled low or released
// - protect pin blocks data ack, writes
// - allowed when pin low or compare matches
// - compare upper bits with latch boundary
// - top-bottom bit set refuses at/above boundary
// - boundary latch fixed, never bus-written
// - SDA changes only while SCL low
// - ignore all until a start
// - stop ends transfer, enters standby
module eei_slave
	import eei_pkg::*;
(
	// Core clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	// Bus pins
	input  wire logic                  scl_clk,
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output      logic                  sda_out,
	output      logic                  sda_oe,
	// Straps and protection
	input  wire logic                  chip_select_input,
	input  wire logic                  wp_pin,
	input  wire logic [BYTE_W-1:0]     protect_boundary_latch,
	// Transfer status
	output      logic                  busy,
	output      logic                  slave_hit,
	output      logic                  read_mode,
	output      logic [1:0]            page_block,
	output      logic [ADDR_W-1:0]     array_addr,
	output      logic                  addr_valid,
	output      logic                  write_allowed,
	// Write data stream
	output      logic [BYTE_W-1:0]     wr_data,
	output      logic                  wr_stb,
	output      logic                  stop_stb
);

	// ==========================================================
	// Link side and synchronisers
	logic [BYTE_W-1:0] link_byte;
	logic              link_tgl;
	logic [SYNC_W-1:0] sy_in;
	logic [SYNC_W-1:0] sy;

	eei_link_rx u_link (
		.scl_clk (scl_clk),
		.resetn  (resetn),
		.sda_in  (sda_in),
		.rx_byte (link_byte),
		.rx_tgl  (link_tgl)
	);

	always_comb begin
		sy_in         = '0;
		sy_in[SY_SCL] = scl_in;
		sy_in[SY_SDA] = sda_in;
		sy_in[SY_TGL] = link_tgl;
		sy_in[SY_WP]  = wp_pin;
		sy_in[SY_CS]  = chip_select_input;
	end

	eei_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.clk      (ref_clk),
		.resetn   (resetn),
		.async_in (sy_in),
		.sync_out (sy)
	);

	// ==========================================================
	// State record
	typedef struct packed {
		eei_state_e        st;
		eei_state_e        after;
		logic [BCNT_W-1:0] bcnt;
		logic              scl_p;
		logic              sda_p;
		logic              tgl_seen;
		logic              ack;
		logic              drove;
		logic              sda_out;
		logic              sda_oe;
		logic              hit;
		logic              rd;
		logic [1:0]        blk;
		logic [ADDR_W-1:0] addr;
		logic              addr_ok;
		logic              wr_ok;
		logic [BYTE_W-1:0] wdat;
		logic              wr_stb;
		logic              stop_stb;
		logic              busy;
	} eei_core_s;

	eei_core_s s_q;
	eei_core_s s_d;

	logic              rise;
	logic              fall;
	logic              start;
	logic              stop;
	logic              match;
	logic              below;
	logic              allow;
	logic [UPPER_W-1:0] upper_address_bits;
	logic [UPPER_W-1:0] boundary;

	// ==========================================================
	// Bus events
	always_comb begin
		rise  = sy[SY_TGL] != s_q.tgl_seen;
		fall  = s_q.scl_p & ~sy[SY_SCL];
		// SDA edge with SCL high is framing
		// start is SDA fall, SCL high
		start = s_q.scl_p & sy[SY_SCL] & s_q.sda_p & ~sy[SY_SDA];
		// stop is SDA rise, SCL high
		stop  = s_q.scl_p & sy[SY_SCL] & ~s_q.sda_p & sy[SY_SDA];
	end

	// ==========================================================
	// Address match and write guard
	always_comb begin
		match = (link_byte[SA_TYPE_HI:SA_TYPE_LO] == DEV_TYPE)
			&& (link_byte[SA_ABSENT] == ABSENT_SEL)
			&& (link_byte[SA_CS] == sy[SY_CS]);
		// latch is a fixed input only
		upper_address_bits = s_q.addr[ADDR_MSB:UPPER_LO];
		boundary = protect_boundary_latch[BYTE_W-1:LATCH_BND_LO];
		below = upper_address_bits < boundary;
		// pin low, or compare agrees with T/B
		// T/B set refuses at or above boundary
		allow = ~sy[SY_WP]
			| (below == protect_boundary_latch[LATCH_TB]);
	end

	// ==========================================================
	// Protocol engine
	always_comb begin
		s_d          = s_q;
		s_d.scl_p    = sy[SY_SCL];
		s_d.sda_p    = sy[SY_SDA];
		s_d.tgl_seen = sy[SY_TGL];
		s_d.wr_stb   = 1'b0;
		s_d.stop_stb = 1'b0;
		s_d.sda_out  = 1'b0;
		if (stop) begin
			s_d.stop_stb = s_q.st != ST_IDLE;
			s_d.st       = ST_IDLE;
			s_d.sda_oe   = 1'b0;
			s_d.drove    = 1'b0;
			s_d.bcnt     = BCNT_RST;
		end else if (start) begin
			s_d.st      = ST_ADDR;
			s_d.sda_oe  = 1'b0;
			s_d.drove   = 1'b0;
			s_d.bcnt    = BCNT_RST;
			s_d.hit     = 1'b0;
			s_d.addr_ok = 1'b0;
		end else begin
			unique case (s_q.st)
			ST_IDLE, ST_HOLD: begin
				s_d.sda_oe = 1'b0;
			end
			ST_ADDR, ST_AHI, ST_ALO, ST_DATA: begin
				if (rise) begin
					if (s_q.bcnt != LAST_BIT) begin
						s_d.bcnt = s_q.bcnt + 4'h1;
					end else begin
						s_d.bcnt = BCNT_RST;
						s_d.ack  = 1'b1;
						unique case (s_q.st)
						ST_ADDR: begin
							s_d.st  = ST_ADDR_ACK;
							s_d.hit = match;
							s_d.ack = match;
							s_d.rd  = link_byte[SA_RW] == RW_READ;
							s_d.addr[ADDR_MSB] = link_byte[SA_MSB];
							s_d.blk = {link_byte[SA_CS],
								link_byte[SA_MSB]};
							if (!match) begin
								s_d.after = ST_HOLD;
							end else if (link_byte[SA_RW] == RW_READ) begin
								s_d.after = ST_HOLD;
							end else begin
								s_d.after = ST_AHI;
							end
						end
						ST_AHI: begin
							s_d.st    = ST_AHI_ACK;
							s_d.addr[ADDR_MSB-1:BYTE_W] = link_byte;
							s_d.after = ST_ALO;
						end
						ST_ALO: begin
							s_d.st      = ST_ALO_ACK;
							s_d.addr[BYTE_W-1:0] = link_byte;
							s_d.addr_ok = 1'b1;
							s_d.after   = ST_DATA;
						end
						default: begin
							s_d.st     = ST_DATA_ACK;
							s_d.wr_ok  = allow;
							s_d.ack    = allow;
							s_d.wdat   = link_byte;
							s_d.wr_stb = allow;
							s_d.after  = allow ? ST_DATA : ST_HOLD;
						end
						endcase
					end
				end
			end
			ST_ADDR_ACK, ST_AHI_ACK, ST_ALO_ACK, ST_DATA_ACK: begin
				// master released SDA for this bit
				if (fall) begin
					if (!s_q.drove) begin
						s_d.sda_oe = s_q.ack;
						s_d.drove  = 1'b1;
					end else begin
						s_d.sda_oe = 1'b0;
						s_d.drove  = 1'b0;
						s_d.st     = s_q.after;
					end
				end
			end
			endcase
		end
		// Registered so the busy pin comes from a flop
		s_d.busy = s_d.st != ST_IDLE;
	end

	// ==========================================================
	// Core registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_q          <= '0;
			s_q.st       <= ST_IDLE;
			s_q.after    <= ST_IDLE;
			s_q.scl_p    <= 1'b1;
			s_q.sda_p    <= 1'b1;
			s_q.addr     <= ADDR_RST;
			s_q.wdat     <= BYTE_RST;
			s_q.bcnt     <= BCNT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs, all from the state record
	assign sda_out       = s_q.sda_out;
	assign sda_oe        = s_q.sda_oe;
	assign busy          = s_q.busy;
	assign slave_hit     = s_q.hit;
	assign read_mode     = s_q.rd;
	assign page_block    = s_q.blk;
	assign array_addr    = s_q.addr;
	assign addr_valid    = s_q.addr_ok;
	assign write_allowed = s_q.wr_ok;
	assign wr_data       = s_q.wdat;
	assign wr_stb        = s_q.wr_stb;
	assign stop_stb      = s_q.stop_stb;

endmodule

/* File: pkg/eei_pkg.sv */
/*
 * Shared constants and types for the two-wire EEPROM slave front end.
 * Assumes: included before every design file that imports it.
 */
package eei_pkg;

	// ==========================================================
	// Widths
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned ADDR_W   = 17;
	localparam int unsigned UPPER_W  = 7;
	localparam int unsigned BCNT_W   = 4;
	localparam int unsigned SYNC_W   = 5;

	// ==========================================================
	// Slave address byte layout
	localparam int unsigned SA_TYPE_HI  = 7;
	localparam int unsigned SA_TYPE_LO  = 4;
	localparam int unsigned SA_ABSENT   = 3;
	localparam int unsigned SA_CS       = 2;
	localparam int unsigned SA_MSB      = 1;
	localparam int unsigned SA_RW       = 0;
	localparam logic [3:0]  DEV_TYPE    = 4'ha;
	localparam logic        ABSENT_SEL  = 1'h0;
	localparam logic        RW_READ     = 1'h1;

	// ==========================================================
	// Array address and boundary latch fields
	localparam int unsigned ADDR_MSB    = 16;
	localparam int unsigned UPPER_LO    = 10;
	localparam int unsigned LATCH_TB    = 0;
	localparam int unsigned LATCH_BND_LO = 1;
	localparam logic [BCNT_W-1:0] LAST_BIT = 4'h7;

	// ==========================================================
	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 17'h0_0000;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic [BCNT_W-1:0] BCNT_RST = 4'h0;

	// ==========================================================
	// Synchroniser vector positions
	localparam int unsigned SY_SCL = 0;
	localparam int unsigned SY_SDA = 1;
	localparam int unsigned SY_TGL = 2;
	localparam int unsigned SY_WP  = 3;
	localparam int unsigned SY_CS  = 4;

	// ==========================================================
	// Protocol states
	typedef enum logic [9:0] {
		ST_IDLE     = 10'b00_0000_0001,
		ST_ADDR     = 10'b00_0000_0010,
		ST_ADDR_ACK = 10'b00_0000_0100,
		ST_AHI      = 10'b00_0000_1000,
		ST_AHI_ACK  = 10'b00_0001_0000,
		ST_ALO      = 10'b00_0010_0000,
		ST_ALO_ACK  = 10'b00_0100_0000,
		ST_DATA     = 10'b00_1000_0000,
		ST_DATA_ACK = 10'b01_0000_0000,
		ST_HOLD     = 10'b10_0000_0000
	} eei_state_e;

endpackage

/* File: src/eei_sync.sv */
/*
 * Three-stage synchroniser with agreement filter, one lane per bit.
 * Assumes: inputs asynchronous to clk; output changes only when the
 * second and third stages agree.
 */
`timescale 1ns/1ps

module eei_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Lanes
	input  wire logic [WIDTH-1:0] async_in,
	output      logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] lvl;
	} eei_sync_s;

	eei_sync_s s_q;
	eei_sync_s s_d;

	// ==========================================================
	// Stage chain; s1 feeds only s2
	always_comb begin
		s_d    = s_q;
		s_d.s1 = async_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (s_q.s2[i] == s_q.s3[i]) begin
				s_d.lvl[i] = s_q.s3[i];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.lvl;

endmodule

/* File: src/eei_link_rx.sv */
/*
 * Link-side receive shifter clocked by the bus clock itself.
 * Assumes: bus clock may stop between frames; the byte is read by
 * the other domain only after the toggle has been synchronised,
 * while the clock is high and the shifter therefore stable.
 */
`timescale 1ns/1ps

module eei_link_rx
	import eei_pkg::*;
(
	// Link clock and reset
	input  wire logic              scl_clk,
	input  wire logic              resetn,
	// Serial data
	input  wire logic              sda_in,
	// To the core domain
	output      logic [BYTE_W-1:0] rx_byte,
	output      logic              rx_tgl
);

	typedef struct packed {
		logic [BYTE_W-1:0] sh;
		logic              tgl;
	} eei_lrx_s;

	eei_lrx_s s_q;
	eei_lrx_s s_d;

	// ==========================================================
	// MSB first on rising edge
	always_comb begin
		s_d     = s_q;
		s_d.sh  = {s_q.sh[BYTE_W-2:0], sda_in};
		s_d.tgl = ~s_q.tgl;
	end

	always_ff @(posedge scl_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rx_byte = s_q.sh;
	assign rx_tgl  = s_q.tgl;

endmodule

/* File: verif/eei_slave_assertions.sv */
/*
 * Concurrent checks on the two-wire slave front end ports.
 * Assumes: bound to eei_slave; all checks on ref_clk.
 */
`timescale 1ns/1ps

module eei_slave_chk
	import eei_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              resetn,
	input wire logic              scl_clk,
	input wire logic              scl_in,
	input wire logic              sda_in,
	input wire logic              sda_out,
	input wire logic              sda_oe,
	input wire logic              chip_select_input,
	input wire logic              wp_pin,
	input wire logic [BYTE_W-1:0] protect_boundary_latch,
	input wire logic              busy,
	input wire logic              slave_hit,
	input wire logic              read_mode,
	input wire logic [1:0]        page_block,
	input wire logic [ADDR_W-1:0] array_addr,
	input wire logic              addr_valid,
	input wire logic              write_allowed,
	input wire logic [BYTE_W-1:0] wr_data,
	input wire logic              wr_stb,
	input wire logic              stop_stb
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// ========
	// Steps
	sequence s_ack_held;
		sda_oe [*8];
	endsequence
	sequence s_back_idle;
		##[0:3] !busy;
	endsequence

	// ========
	// Checks
	AST_OPEN_DRAIN:
	assert property (sda_oe |-> !sda_out) else $error("sda driven high");
	AST_OE_SCL_LOW:
	assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda moved with scl high");
	AST_ACK_HELD:
	assert property ($rose(sda_oe) |-> s_ack_held) else $error("ack too short");
	AST_ACK_HIT:
	assert property ($rose(sda_oe) |-> ##[0:4] slave_hit)
		else $error("ack without match");
	AST_IDLE_QUIET:
	assert property (!busy |-> !sda_oe) else $error("sda pulled while idle");
	AST_STOP_IDLE:
	assert property (stop_stb |-> s_back_idle) else $error("no idle after stop");
	AST_WR_COND:
	assert property (wr_stb |-> addr_valid && slave_hit && !read_mode)
		else $error("write strobe out of place");
	AST_WR_GUARD:
	assert property (wr_stb |-> ##[0:1] write_allowed)
		else $error("write strobe while guarded");
	AST_BLK_MSB:
	assert property ($rose(addr_valid) |-> page_block[0] == array_addr[ADDR_MSB])
		else $error("block bit and address msb differ");
	AST_SEL_CS:
	assert property ($rose(slave_hit) |-> page_block[1] == chip_select_input)
		else $error("select bit differs from strap");
endmodule

bind eei_slave eei_slave_chk eei_slave_chk_i (
	.ref_clk(ref_clk), .resetn(resetn), .scl_clk(scl_clk), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.chip_select_input(chip_select_input), .wp_pin(wp_pin),
	.protect_boundary_latch(protect_boundary_latch), .busy(busy),
	.slave_hit(slave_hit), .read_mode(read_mode), .page_block(page_block),
	.array_addr(array_addr), .addr_valid(addr_valid),
	.write_allowed(write_allowed), .wr_data(wr_data), .wr_stb(wr_stb),
	.stop_stb(stop_stb)
);

/* File: verif/eei_mst.sv */
/*
 * Behavioural two-wire bus master driving SCL and pulling SDA.
 * Assumes: SDA is resolved with a pull-up outside; each SCL phase
 * lasts four ticks of the 48 ns link tick, eight for the high phase of a start; SCL parks high.
 */
`timescale 1ns/1ps

module eei_mst (
	// Tick and bus
	input  wire logic link_clk,
	input  wire logic sda_in,
	output      logic scl,
	output      logic sda_pull
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// ========
	// Bus cycles
	task automatic tk(input int n);
		repeat (n) @(posedge link_clk);
	endtask
	task automatic start();
		sda_pull <= 1'b0;
		tk(2);
		scl <= 1'b1;
		tk(4);
		sda_pull <= 1'b1;
		tk(4);
		scl <= 1'b0;
		tk(2);
	endtask
	task automatic xfer(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_pull <= !b[i];
			tk(2);
			scl <= 1'b1;
			tk(4);
			scl <= 1'b0;
			tk(2);
		end
		sda_pull <= 1'b0;
		tk(2);
		scl <= 1'b1;
		tk(2);
		ack = !sda_in;
		tk(2);
		scl <= 1'b0;
		tk(2);
	endtask
	task automatic stop();
		sda_pull <= 1'b1;
		tk(2);
		scl <= 1'b1;
		tk(4);
		sda_pull <= 1'b0;
		tk(4);
	endtask
endmodule

/* File: verif/tb_eei_slave.sv */
/*
 * Self-checking bench for the two-wire slave front end.
 * Assumes: eei_mst plays the bus master; write strobes are noted in
 * a queue and matched by a watcher process.
 */
`timescale 1ns/1ps

module tb_eei_slave;
	import eei_pkg::*;
	logic ref_clk = 1'b0, link_clk = 1'b0, resetn = 1'b0;
	logic cs = 1'b1, wp = 1'b0;
	logic [BYTE_W-1:0] latch = 8'h00;
	logic scl, pull, sda_out, sda_oe, busy, slave_hit, read_mode;
	logic addr_valid, write_allowed, wr_stb, stop_stb;
	logic [1:0] page_block;
	logic [ADDR_W-1:0] array_addr;
	logic [BYTE_W-1:0] wr_data;
	logic [24:0] exp_q[$];
	logic [24:0] e;
	logic [31:0] rs = 32'h0000_0042;
	int fails = 0, num_checks = 0;
	int n_stop = 0, exp_stop = 0;
	// Pull-up: released line reads high
	wire logic sda = !((sda_oe & ~sda_out) | pull);

	initial forever #2 ref_clk = ~ref_clk;
	initial begin
		#7;
		forever #24 link_clk = ~link_clk;
	end

	eei_mst eei_mst_i (.link_clk(link_clk), .sda_in(sda), .scl(scl),
		.sda_pull(pull));
	eei_slave eei_slave_i (.ref_clk(ref_clk), .resetn(resetn),
		.scl_clk(scl), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .chip_select_input(cs), .wp_pin(wp),
		.protect_boundary_latch(latch), .busy(busy), .slave_hit(slave_hit),
		.read_mode(read_mode), .page_block(page_block),
		.array_addr(array_addr), .addr_valid(addr_valid),
		.write_allowed(write_allowed), .wr_data(wr_data), .wr_stb(wr_stb),
		.stop_stb(stop_stb));

	// ========
	// Helpers
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			fails++;
			$display("[ERR] %s expected %0h seen %0h", nm, ex, got);
		end
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 200 && busy !== 1'b0; i++)
			@(posedge ref_clk);
		if (i == 200) begin
			fails++;
			$display("[ERR] busy expected 0 seen %0b", busy);
			report_and_stop();
		end
		repeat (10) @(posedge ref_clk);
		exp_stop++;
		chk("stop_cnt", exp_stop, n_stop);
	endtask
	task automatic wr_txn(input logic [16:0] ad, input logic [7:0] d);
		logic a;
		logic ok;
		ok = !wp || ((ad[16:10] < latch[7:1]) == latch[0]);
		eei_mst_i.start();
		eei_mst_i.xfer({4'ha, 1'b0, cs, ad[16], 1'b0}, a);
		chk("sa_ack", 1, a);
		eei_mst_i.xfer(ad[15:8], a);
		chk("hi_ack", 1, a);
		eei_mst_i.xfer(ad[7:0], a);
		chk("lo_ack", 1, a);
		chk("addr", ad, array_addr);
		chk("blk", {cs, ad[16]}, page_block);
		chk("addr_ok", 1, addr_valid);
		repeat (2) begin
			if (ok)
				exp_q.push_back({ad, d});
			eei_mst_i.xfer(d, a);
			chk("d_ack", ok, a);
			d = d + 8'h01;
		end
		chk("wr_ok", ok, write_allowed);
		eei_mst_i.stop();
		wait_idle();
	endtask

	// ========
	// Watcher
	always @(posedge ref_clk) begin
		if (stop_stb === 1'b1)
			n_stop++;
		if (wr_stb === 1'b1) begin
			if (exp_q.size() == 0)
				chk("wr_extra", 0, 1);
			else begin
				e = exp_q.pop_front();
				chk("wr_data", e[7:0], wr_data);
				chk("wr_addr", e[24:8], array_addr);
			end
		end
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		fails++;
		$display("[ERR] run expected end seen timeout");
		report_and_stop();
	end

	// ========
	// Sequence
	initial begin
		logic a;
		logic [7:0] sa;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (10) @(posedge ref_clk);
		eei_mst_i.xfer(8'ha4, a);
		chk("no_start", 0, a);
		$display("test no_start done");
		for (int k = 0; k < 4; k++) begin
			sa = k == 0 ? 8'ha4 : k == 1 ? 8'ha0 : k == 2 ? 8'hac : 8'hb4;
			eei_mst_i.start();
			eei_mst_i.xfer(sa, a);
			chk("sel_ack", k == 0, a);
			chk("hit", k == 0, slave_hit);
			eei_mst_i.stop();
			wait_idle();
		end
		$display("test select done");
		eei_mst_i.start();
		eei_mst_i.xfer(8'ha5, a);
		chk("rd_ack", 1, a);
		chk("rd_mode", 1, read_mode);
		eei_mst_i.start();
		eei_mst_i.xfer(8'ha4, a);
		chk("rs_mode", 0, read_mode);
		eei_mst_i.stop();
		wait_idle();
		$display("test read done");
		wr_txn(17'(rnd()), 8'(rnd()));
		$display("test write done");
		@(posedge ref_clk);
		wp <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk);
			latch <= k == 0 ? 8'h01 : k == 1 ? 8'h80 : k == 2 ? 8'hc1 : 8'h00;
			// strap low for the first two
			cs <= k[1];
			repeat (10) @(posedge ref_clk);
			wr_txn({k[0], 16'(rnd())}, 8'(rnd()));
		end
		$display("test protect done");
		chk("q_empty", 0, exp_q.size());
		report_and_stop();
	end
endmodule
